// ---- hdl/urp_defs.vh ----
`ifndef URP_DEFS_VH
`define URP_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------------
`define URP_OFS_DATA        5'h00
`define URP_OFS_STATUS      5'h04
`define URP_OFS_CTRL        5'h08
`define URP_OFS_IRQ_STAT    5'h0C
`define URP_OFS_IRQ_MASK    5'h10

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define URP_CTRL_RX_EN      0
`define URP_CTRL_ODD        1
`define URP_CTRL_CHECK_EN   2
`define URP_STAT_PE         2
`define URP_STAT_FE         4
`define URP_STAT_BUSY       6
`define URP_STAT_RXC        7
`define URP_IRQ_RXC         0
`define URP_IRQ_PE          1

// ----------------------------------------------------------------------------
// Reset values and frame geometry.
// ----------------------------------------------------------------------------
`define URP_CTRL_RST        3'h0
`define URP_MASK_RST        2'h0
`define URP_DATA_BITS       4'h8
`define URP_BUF_DEPTH       2'h2
`define URP_WAIT_CYCLES     1

`endif

// ---- hdl/urp_rx.v ----
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "urp_defs.vh"

module urp_rx
(
    input  wire        mclk,
    input  wire        resetn,
    // Avalon-MM slave.
    input  wire [4:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output wire        avs_waitrequest,
    output wire [31:0] avs_readdata,
    // Serial input pin and its hand-over to the port function.
    input  wire        rxd_pin,
    output wire        rxd_line,
    output wire        rxd_pin_override,
    // Bits delivered by the clock and data recovery unit.
    input  wire        frame_start,
    input  wire        bit_strobe,
    input  wire        bit_value,
    output wire        receiver_enable_bit,
    output wire        rx_busy,
    output wire        irq
);

    // ------------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------------
    // Register file and bus slave.
    reg  [2:0]  ctrl_q;
    reg  [1:0]  irq_mask_q;
    reg  [1:0]  irq_stat_q;
    reg  [1:0]  irq_stat_d;
    reg         ack_q;
    reg  [31:0] rdata_q;
    reg  [7:0]  status_word;
    // Pin synchroniser.
    reg  [2:0]  pin_sync_q;
    reg         line_q;
    // Frame assembly.
    reg         busy_q;
    reg  [3:0]  bit_cnt_q;
    reg  [7:0]  shift_q;
    reg         par_bit_q;
    reg         chk_q;
    // Receive buffer.
    reg  [9:0]  buf_mem [0:1];
    reg         rd_ptr_q;
    reg         wr_ptr_q;
    reg  [1:0]  count_q;
    // Combinational glue.
    wire        req;
    wire        acc;
    wire        wr_ok;
    wire        ctrl_wr;
    wire        mask_wr;
    wire        stat_wr;
    wire        pop;
    wire        push;
    wire        accept;
    wire        last_bit;
    wire        mismatch;
    wire [9:0]  head;
    wire        parity_check_enable_bit;
    wire        parity_odd_select_bit;
    wire        receive_complete_flag;
    wire        parity_error_flag;
    wire        frame_error_flag;

    // Even parity is a zero XOR over data and parity bit, odd parity a one.
    function parity_bad;
        input [7:0] data;
        input       par;
        input       odd;
        begin
            parity_bad = ((^data) ^ par) != odd;
        end
    endfunction

    // Decodes one register offset; the read mux, the write path and the pop
    // all go through here so that they can never disagree on the map.
    function addr_hit;
        input [4:0] addr;
        input [4:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    // A finished frame enters the buffer when there is room, or when the head
    // leaves in the same cycle and frees the slot that the frame lands in.
    function buf_accept;
        input       fin;
        input [1:0] fill;
        input       leaving;
        begin
            buf_accept = fin & ((fill != `URP_BUF_DEPTH) | leaving);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Bus slave: one wait state, so every access completes on the second edge.
    // ------------------------------------------------------------------------
    assign req             = avs_read | avs_write;
    assign acc             = req & ack_q;
    assign wr_ok           = avs_write & acc & avs_byteenable[0];
    assign avs_waitrequest = req & ~ack_q;
    assign avs_readdata    = rdata_q;

    // Write strobes per register, each fired only at the completing edge.
    assign ctrl_wr = wr_ok & addr_hit(avs_address, `URP_OFS_CTRL);
    assign mask_wr = wr_ok & addr_hit(avs_address, `URP_OFS_IRQ_MASK);
    assign stat_wr = wr_ok & addr_hit(avs_address, `URP_OFS_IRQ_STAT);

    // Control fields as the rest of the port sees them.
    assign receiver_enable_bit     = ctrl_q[`URP_CTRL_RX_EN];
    assign parity_odd_select_bit   = ctrl_q[`URP_CTRL_ODD];
    assign parity_check_enable_bit = ctrl_q[`URP_CTRL_CHECK_EN];

    // Status seen by software always describes the oldest unread entry.
    assign head                  = buf_mem[rd_ptr_q];
    assign receive_complete_flag = (count_q != 2'h0);
    assign parity_error_flag     = receive_complete_flag & head[9];
    assign frame_error_flag      = receive_complete_flag & head[8];

    // The entry is consumed only when the data read actually completes.
    assign pop = avs_read & acc & addr_hit(avs_address, `URP_OFS_DATA) & receive_complete_flag;

    // Status byte built from the field positions; unused bits read zero.
    always @*
    begin
        status_word                 = 8'h00;
        status_word[`URP_STAT_RXC]  = receive_complete_flag;
        status_word[`URP_STAT_BUSY] = busy_q;
        status_word[`URP_STAT_FE]   = frame_error_flag;
        status_word[`URP_STAT_PE]   = parity_error_flag;
    end

    // Acknowledge toggles so back-to-back requests each see a wait state.
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            ack_q <= 1'b0;
        else
            ack_q <= req & ~ack_q;
    end

    // Read data is captured in the wait cycle and stands at the completing edge.
    // Reading an empty buffer returns zero, and pops a frame only if one lands in the wait cycle.
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rdata_q <= 32'h0000_0000;
        else if (avs_read & ~ack_q)
        begin
            if (addr_hit(avs_address, `URP_OFS_DATA))
                rdata_q <= {24'h00_0000, receive_complete_flag ? head[7:0] : 8'h00};
            else if (addr_hit(avs_address, `URP_OFS_STATUS))
                rdata_q <= {24'h00_0000, status_word};
            else if (addr_hit(avs_address, `URP_OFS_CTRL))
                rdata_q <= {29'h0000_0000, ctrl_q};
            else if (addr_hit(avs_address, `URP_OFS_IRQ_STAT))
                rdata_q <= {30'h0000_0000, irq_stat_q};
            else if (addr_hit(avs_address, `URP_OFS_IRQ_MASK))
                rdata_q <= {30'h0000_0000, irq_mask_q};
            else
                rdata_q <= 32'h0000_0000;
        end
    end

    // Control and mask registers; interrupt status writes clear events, writes to other offsets are ignored.
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_q     <= `URP_CTRL_RST;
            irq_mask_q <= `URP_MASK_RST;
        end
        else
        begin
            if (ctrl_wr)
                ctrl_q <= avs_writedata[2:0];
            if (mask_wr)
                irq_mask_q <= avs_writedata[1:0];
        end
    end

    // ------------------------------------------------------------------------
    // Serial pin: three-stage synchroniser, a change counts once two agree.
    // ------------------------------------------------------------------------
    // The first stage may go metastable, so only stages two and three are
    // compared: a level must stand two clocks before the filter follows it.
    // All stages reset to the idle level so no false edge follows reset.
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_sync_q <= 3'h7;
            line_q     <= 1'b1;
        end
        else
        begin
            pin_sync_q <= {pin_sync_q[1:0], rxd_pin};
            if (pin_sync_q[1] == pin_sync_q[2])
                line_q <= pin_sync_q[2];
        end
    end

    // Idle level is shown while the receiver has let go of the pin.
    assign rxd_line         = receiver_enable_bit ? line_q : 1'b1;
    assign rxd_pin_override = receiver_enable_bit;

    // ------------------------------------------------------------------------
    // Frame assembly: data bits LSB first, parity bit if checking, stop bit.
    // ------------------------------------------------------------------------
    // The parity bit is expected only while checking is on, so the last bit
    // index moves with the check-enable setting latched at frame start.
    assign last_bit = chk_q ? (bit_cnt_q == `URP_DATA_BITS + 4'h1)
                            : (bit_cnt_q == `URP_DATA_BITS);
    assign push     = busy_q & bit_strobe & last_bit & receiver_enable_bit;
    assign accept   = buf_accept(push, count_q, pop);
    assign mismatch = chk_q & parity_bad(shift_q, par_bit_q, parity_odd_select_bit);
    assign rx_busy  = busy_q;

    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            busy_q    <= 1'b0;
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
            par_bit_q <= 1'b0;
            chk_q     <= 1'b0;
        end
        else if (!receiver_enable_bit)
        begin
            // Partial frame is dropped on the spot.
            busy_q    <= 1'b0;
            bit_cnt_q <= 4'h0;
        end
        else if (frame_start)
        begin
            // Check enable is captured here so that a change in mid-frame
            // cannot move the position of the parity bit.
            busy_q    <= 1'b1;
            bit_cnt_q <= 4'h0;
            chk_q     <= parity_check_enable_bit;
        end
        else if (busy_q & bit_strobe)
        begin
            // Data shifts in LSB first; the bit after the data is parity when checked.
            if (bit_cnt_q < `URP_DATA_BITS)
                shift_q <= {bit_value, shift_q[7:1]};
            else if (chk_q & (bit_cnt_q == `URP_DATA_BITS))
                par_bit_q <= bit_value;
            if (last_bit)
                busy_q <= 1'b0;
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Two-entry receive buffer: {parity error, frame error, data}.
    // ------------------------------------------------------------------------
    // A frame arriving with both entries full and no pop in that cycle is lost;
    // no overrun is reported. A pop and a push in the same cycle both take effect.
    always @(posedge mclk)
    begin
        if (accept)
            buf_mem[wr_ptr_q] <= {mismatch, ~bit_value, shift_q};
    end

    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end
        else if (!receiver_enable_bit)
        begin
            // All unread entries are discarded while disabled.
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end
        else
        begin
            // Pointers and fill level move on the same edge, so the complete
            // flag never runs ahead of the entry it announces.
            if (pop)
                rd_ptr_q <= ~rd_ptr_q;
            if (accept)
                wr_ptr_q <= ~wr_ptr_q;
            if (accept && !pop)
                count_q <= count_q + 2'h1;
            else if (pop && !accept)
                count_q <= count_q - 2'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupts: sticky events, write one to clear, a new event wins.
    // ------------------------------------------------------------------------
    always @*
    begin
        irq_stat_d = irq_stat_q;
        if (stat_wr)
            irq_stat_d = irq_stat_q & ~avs_writedata[1:0];
        if (push)
            irq_stat_d[`URP_IRQ_RXC] = 1'b1;
        if (push && mismatch)
            irq_stat_d[`URP_IRQ_PE] = 1'b1;
    end

    // Sticky event register.
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            irq_stat_q <= 2'h0;
        else
            irq_stat_q <= irq_stat_d;
    end

    // Level output: stays high until software clears or masks every source.
    assign irq = |(irq_stat_q & irq_mask_q);

endmodule // urp_rx

// ---- verif/urp_rx_monitor.sv ----
`timescale 1ns/1ps
`include "urp_defs.vh"
// ----------------------------------------------------------------------------
// Port checks for the receiver.
// ----------------------------------------------------------------------------
module urp_rx_monitor
(
    input wire        mclk,
    input wire        resetn,
    input wire [4:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire        avs_waitrequest,
    input wire [31:0] avs_readdata,
    input wire        rxd_line,
    input wire        rxd_pin_override,
    input wire        receiver_enable_bit,
    input wire        rx_busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // A request is taken in the cycle where waitrequest has dropped.
    wire req  = avs_read | avs_write;
    wire take = req & ~avs_waitrequest;
    pin_release_a: assert property (!receiver_enable_bit |-> !rxd_pin_override)
        else $error("pin held while disabled");
    line_idle_a: assert property (!receiver_enable_bit |-> rxd_line)
        else $error("line not idle while disabled");
    abort_busy_a: assert property (!receiver_enable_bit |=> !rx_busy)
        else $error("frame kept after disable");
    wait_first_a: assert property (req && !$past(req) |-> avs_waitrequest)
        else $error("no wait state");
    wait_once_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait state too long");
    data_stand_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data moved");
    enable_write_a: assert property ($changed(receiver_enable_bit) |-> $past(take && avs_write
        && avs_address == `URP_OFS_CTRL && avs_byteenable[0]) && receiver_enable_bit == $past(avs_writedata[0]))
        else $error("enable changed without write");
    flush_status_a: assert property (take && avs_read && avs_address == `URP_OFS_STATUS && !receiver_enable_bit
        && !$past(receiver_enable_bit, 2) |-> avs_readdata[7:0] == 8'h00)
        else $error("status not empty while disabled");
    cover property ($fell(rx_busy));
    cover property ($fell(receiver_enable_bit));
    cover property (take && avs_read);
endmodule // urp_rx_monitor

bind urp_rx urp_rx_monitor u_mon (.mclk(mclk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .rxd_line(rxd_line),
    .rxd_pin_override(rxd_pin_override), .receiver_enable_bit(receiver_enable_bit), .rx_busy(rx_busy));

// ---- verif/urp_tx_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Remote transmitter as seen through the recovery unit.
// ----------------------------------------------------------------------------
module urp_tx_model
(
    input  wire mclk,
    output reg  frame_start = 1'b0,
    output reg  bit_strobe  = 1'b0,
    output reg  bit_value   = 1'b0,
    output reg  rxd_pin     = 1'b1
);
    // Sends one frame; gap idle cycles per bit model a slow sender.
    task send(input [7:0] d, input pen, input pbit, input stp, input integer gap);
        integer i;
        reg [9:0] b;
        b = pen ? {stp, pbit, d} : {1'b0, stp, d};
        frame_start <= 1'b1;
        rxd_pin     <= 1'b0;
        @(posedge mclk);
        frame_start <= 1'b0;
        for (i = 0; i < (pen ? 10 : 9); i = i + 1)
        begin
            bit_strobe <= 1'b1;
            bit_value  <= b[i];
            rxd_pin    <= b[i];
            @(posedge mclk);
            if (gap > 0)
            begin
                bit_strobe <= 1'b0;
                bit_value  <= ~b[i]; // A stale bit is not left standing in the gap.
                repeat (gap) @(posedge mclk);
            end
        end
        bit_strobe <= 1'b0;
        bit_value  <= ~bit_value;
        rxd_pin    <= 1'b1;
        @(posedge mclk);
    endtask
endmodule // urp_tx_model

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`include "urp_defs.vh"
module testbench;
    reg         mclk = 1'b0;
    reg         resetn = 1'b0;
    reg  [4:0]  avs_address = 5'h00;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h0;
    reg  [3:0]  avs_byteenable = 4'hF;
    reg  [31:0] q;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, rxd_line, rxd_pin_override, receiver_enable_bit, rx_busy, irq;
    wire        frame_start, bit_strobe, bit_value, rxd_pin;
    integer     num_errors = 0;
    integer     n_compared = 0;
    integer     cyc = 0;
    integer     o, p, k;

    always #5 mclk = ~mclk;

    urp_rx u_dut (.mclk(mclk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .rxd_pin(rxd_pin), .rxd_line(rxd_line),
        .rxd_pin_override(rxd_pin_override), .frame_start(frame_start), .bit_strobe(bit_strobe),
        .bit_value(bit_value), .receiver_enable_bit(receiver_enable_bit), .rx_busy(rx_busy), .irq(irq));
    urp_tx_model u_tx (.mclk(mclk), .frame_start(frame_start), .bit_strobe(bit_strobe),
        .bit_value(bit_value), .rxd_pin(rxd_pin));

    task print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // One bus cycle; an idle edge follows so the next request never rises in the same step.
    task bus(input w, input [4:0] a, input [31:0] d);
        avs_write     <= w;
        avs_read      <= !w;
        avs_address   <= a;
        avs_writedata <= d;
        @(posedge mclk iff avs_waitrequest === 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge mclk);
    endtask

    task rc(input [4:0] a, input [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    // A hung handshake is cut short here and counted.
    always @(posedge mclk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            num_errors = num_errors + 1;
            print_verdict;
        end
    end

    initial
    begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        chk(rxd_pin_override, 32'h0);
        chk(rxd_line, 32'h1);
        bus(1'b1, `URP_OFS_CTRL, 32'h1);
        u_tx.send(8'hA7, 1'b0, 1'b0, 1'b1, 0);
        rc(`URP_OFS_STATUS, 32'h80);
        rc(`URP_OFS_DATA, 32'hA7);
        $display("parity off test done");
        // Every sense and parity bit; the odd-select also picks a fast or slow sender.
        for (o = 0; o < 2; o = o + 1)
            for (p = 0; p < 2; p = p + 1)
            begin
                bus(1'b1, `URP_OFS_CTRL, 5 + 2 * o);
                u_tx.send(8'hA7, 1'b1, p, 1'b1, o);
                rc(`URP_OFS_STATUS, 32'h80 + 4 * ((1 ^ p) != o));
                rc(`URP_OFS_DATA, 32'hA7);
            end
        $display("parity mode test done");
        bus(1'b1, `URP_OFS_CTRL, 32'h5);
        u_tx.send(8'h01, 1'b1, 1'b0, 1'b1, 0);
        u_tx.send(8'h03, 1'b1, 1'b0, 1'b0, 1);
        rc(`URP_OFS_STATUS, 32'h84);
        rc(`URP_OFS_DATA, 32'h01);
        rc(`URP_OFS_STATUS, 32'h90);
        rc(`URP_OFS_DATA, 32'h03);
        rc(`URP_OFS_STATUS, 32'h0);
        u_tx.send(8'h55, 1'b1, 1'b0, 1'b1, 0);
        u_tx.send(8'h66, 1'b1, 1'b0, 1'b1, 0);
        k = 0;
        bus(1'b0, `URP_OFS_STATUS, 32'h0);
        while (q[7] === 1'b1 && k < 5)
        begin
            bus(1'b0, `URP_OFS_DATA, 32'h0);
            k = k + 1;
            bus(1'b0, `URP_OFS_STATUS, 32'h0);
        end
        chk(k, 32'h2);
        $display("buffer test done");
        // Disable with one entry queued and a frame half received.
        u_tx.send(8'h11, 1'b1, 1'b0, 1'b1, 0);
        fork
            u_tx.send(8'h00, 1'b1, 1'b0, 1'b1, 1);
            begin
                repeat (5) @(posedge mclk);
                chk(rxd_line, 32'h0);
                chk(rx_busy, 32'h1);
                bus(1'b1, `URP_OFS_CTRL, 32'h4);
                @(posedge mclk);
                chk(rx_busy, 32'h0);
                chk(rxd_line, 32'h1);
            end
        join
        rc(`URP_OFS_STATUS, 32'h0);
        rc(`URP_OFS_DATA, 32'h0);
        bus(1'b1, `URP_OFS_CTRL, 32'h5);
        rc(`URP_OFS_STATUS, 32'h0);
        $display("disable test done");
        bus(1'b1, `URP_OFS_IRQ_MASK, 32'h0);
        bus(1'b1, `URP_OFS_IRQ_STAT, 32'h3);
        rc(`URP_OFS_IRQ_STAT, 32'h0);
        u_tx.send(8'h01, 1'b1, 1'b0, 1'b1, 0);
        rc(`URP_OFS_IRQ_STAT, 32'h3);
        chk(irq, 32'h0);
        bus(1'b1, `URP_OFS_IRQ_MASK, 32'h3);
        chk(irq, 32'h1);
        bus(1'b1, `URP_OFS_IRQ_STAT, 32'h1);
        chk(irq, 32'h1);
        bus(1'b1, `URP_OFS_IRQ_STAT, 32'h2);
        chk(irq, 32'h0);
        rc(`URP_OFS_DATA, 32'h01);
        rc(5'h14, 32'h0);
        rc(`URP_OFS_IRQ_MASK, 32'h3);
        avs_byteenable <= 4'h0;
        bus(1'b1, `URP_OFS_CTRL, 32'h0);
        avs_byteenable <= 4'hF;
        rc(`URP_OFS_CTRL, 32'h5);
        $display("interrupt test done");
        print_verdict;
    end
endmodule // testbench
